// ===== ppm_pkg.sv
// Constants and types for the transceiver pin mode and strap controller.
// Assumes a single 250 MHz system clock drives every register.
package ppm_pkg;

  // Clock and reset stretch timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int RST_EXT_NS = 258000;
  // Least time, so round up to whole cycles
  localparam int RST_EXT_CYC =
    (RST_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 17;
  localparam logic [RST_CNT_W-1:0] RST_CNT_LAST = 17'h00001;

  // MII and LED geometry
  localparam int MII_NIB_W = 4;
  localparam int LED_NUM = 3;
  localparam int LED_SEL_W = 2;

  // Strap bit positions, taken from the LED pins at reset end
  localparam int STRAP_AN_BIT = 0;
  localparam int STRAP_SPD_BIT = 1;
  localparam int STRAP_FDX_BIT = 2;

  // Per-LED status selections
  localparam logic [LED_SEL_W-1:0] LED_OPT_LINK = 2'h0;
  localparam logic [LED_SEL_W-1:0] LED_OPT_SPEED = 2'h1;
  localparam logic [LED_SEL_W-1:0] LED_OPT_DUPLEX = 2'h2;
  localparam logic [LED_SEL_W-1:0] LED_OPT_ACT = 2'h3;

  // Pin operating modes
  typedef enum logic [2:0] {
    MD_NORMAL = 3'b000,
    MD_HWRST  = 3'b001,
    MD_SFTPD  = 3'b010,
    MD_HWPD   = 3'b011,
    MD_ISO    = 3'b100,
    MD_SLEEP  = 3'b101
  } ppm_mode_t;

  // Line condition resolution states
  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_NEG  = 2'b01,
    LK_UP   = 2'b10
  } ppm_link_t;

endpackage : ppm_pkg

// ===== ppm_pin_mode_ctrl.sv
// Pin mode controller: MII pin states per mode, reset stretch, LED
// strap capture and LED drive, line condition resolution, test port edges.
// Assumes every input is synchronous to clk_sys_i, test clock included.
`timescale 1ns/10ps

// Overview of operation
// - Reset, soft power-down, sleep drive MII data outputs low
// - Weak pull-down on transmit inputs in low modes
// - Hardware power-down floats every MII and LED pin, no pulls
// - Isolate floats outputs and clocks with pull-down
// - Test data input sampled on test clock rise
// - Test data output changes on test clock fall
// - Each LED shows one selected status condition
// - LED pins read straps first, then drive
// - Straps pick forced mode, else negotiate or detect
// - Negotiate using link pulse bursts with capable partner
// - Parallel detect: link pulses 10, idles 100
// - Half and full duplex at both speeds
// - Reset pin OR soft bit, stretched 258 us
module ppm_pin_mode_ctrl
  import ppm_pkg::*;
#(
  parameter int RST_CYC = RST_EXT_CYC  // Reset stretch in clocks
) (
  input wire logic clk_sys_i,                   // System clock
  input wire logic resetn_i,                    // Async reset, low
  input wire logic soft_reset_i,                // Control reset bit
  input wire logic hardware_power_down_mode_i,  // Power-down pin
  input wire logic soft_power_down_mode_i,      // Soft power-down
  input wire logic isolate_i,                   // Isolate request
  input wire logic sleep_i,                     // Sleep request
  input wire logic [MII_NIB_W-1:0] core_rxd_i,  // Core receive data
  input wire logic core_rx_dv_i,                // Core receive valid
  input wire logic core_rx_er_i,                // Core receive error
  input wire logic core_col_i,                  // Core collision
  input wire logic core_crs_i,                  // Core carrier sense
  input wire logic core_tx_clk_i,               // Core transmit clock
  input wire logic core_rx_clk_i,               // Core receive clock
  output logic [MII_NIB_W-1:0] mii_rxd_o,       // Receive data pins
  output logic mii_rx_dv_o,                     // Receive valid pin
  output logic mii_rx_er_o,                     // Receive error pin
  output logic mii_col_o,                       // Collision pin
  output logic mii_crs_o,                       // Carrier sense pin
  output logic mii_tx_clk_o,                    // Transmit clock pin
  output logic mii_rx_clk_o,                    // Receive clock pin
  output logic mii_out_oe_o,                    // Output pins driven
  output logic mii_out_pd_o,                    // Output weak pulls
  output logic mii_tx_pd_o,                     // Tx input weak pulls
  input wire logic [LED_NUM-1:0] led_pin_i,     // LED pin levels
  output logic [LED_NUM-1:0] led_pin_o,         // LED pin drive
  output logic [LED_NUM-1:0] led_pin_oe_o,      // LED pin enables
  input wire logic [LED_NUM*LED_SEL_W-1:0] led_sel_i, // LED selects
  input wire logic activity_i,                  // Line activity
  input wire logic partner_flp_i,               // Partner bursts seen
  input wire logic an_complete_i,               // Negotiation done
  input wire logic an_speed100_i,               // Negotiated 100
  input wire logic an_full_dx_i,                // Negotiated full
  input wire logic nlp_det_i,                   // Link pulses seen
  input wire logic idle_det_i,                  // Idle symbols seen
  input wire logic link_lost_i,                 // Line dropped
  output logic flp_tx_en_o,                     // Send pulse bursts
  output logic link_up_o,                       // Line resolved
  output logic speed100_o,                      // 100 Mbps selected
  output logic full_dx_o,                       // Full duplex
  output logic an_enable_o,                     // Strap: negotiate
  input wire logic tck_i,                       // Test clock level
  input wire logic tdi_i,                       // Test data in
  output logic tdo_o                            // Test data out
);

  // Picks one status condition for an LED
  function automatic logic led_pick(input logic [LED_SEL_W-1:0] sel,
                                    input logic lnk, input logic spd,
                                    input logic fdx, input logic act);
    logic v;
    v = lnk;
    case (sel)
      LED_OPT_LINK: v = lnk;
      LED_OPT_SPEED: v = spd;
      LED_OPT_DUPLEX: v = fdx;
      LED_OPT_ACT: v = act;
      default: v = lnk;
    endcase
    return v;
  endfunction : led_pick

  logic [RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
  logic [LED_NUM-1:0] strap_r, strap_nxt;
  logic in_rst;
  ppm_mode_t mode_w;

  // Reset stretch: the pin reset and the soft bit both restart it
  always_comb begin
    rst_cnt_nxt = rst_cnt_r;
    strap_nxt = strap_r;
    if (soft_reset_i) begin
      rst_cnt_nxt = RST_CNT_W'(RST_CYC);
    end else if (rst_cnt_r != '0) begin
      rst_cnt_nxt = rst_cnt_r - RST_CNT_W'(1);
    end
    // LED drivers are off in reset, so the straps are readable here
    if (rst_cnt_r == RST_CNT_LAST && !soft_reset_i) begin
      strap_nxt = led_pin_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_cnt_r <= RST_CNT_W'(RST_CYC);
      strap_r <= '0;
    end else begin
      rst_cnt_r <= rst_cnt_nxt;
      strap_r <= strap_nxt;
    end
  end

  assign in_rst = (rst_cnt_r != '0);
  assign an_enable_o = strap_r[STRAP_AN_BIT];

  // Mode priority; power-down first since it must cut every pull
  always_comb begin
    if (hardware_power_down_mode_i) begin
      mode_w = MD_HWPD;
    end else if (in_rst) begin
      mode_w = MD_HWRST;
    end else if (isolate_i) begin
      mode_w = MD_ISO;
    end else if (soft_power_down_mode_i) begin
      mode_w = MD_SFTPD;
    end else if (sleep_i) begin
      mode_w = MD_SLEEP;
    end else begin
      mode_w = MD_NORMAL;
    end
  end

  logic [MII_NIB_W-1:0] rxd_r, rxd_nxt;
  logic dv_r, dv_nxt, er_r, er_nxt, col_r, col_nxt, crs_r, crs_nxt;
  logic txc_r, txc_nxt, rxc_r, rxc_nxt;
  logic oe_r, oe_nxt, opd_r, opd_nxt, tpd_r, tpd_nxt;

  // MII pin states per mode; all registered to keep glitches off pins
  always_comb begin
    rxd_nxt = core_rxd_i;
    dv_nxt = core_rx_dv_i;
    er_nxt = core_rx_er_i;
    col_nxt = core_col_i;
    crs_nxt = core_crs_i;
    txc_nxt = core_tx_clk_i;
    rxc_nxt = core_rx_clk_i;
    oe_nxt = 1'b1;
    opd_nxt = 1'b0;
    tpd_nxt = 1'b1;
    case (mode_w)
      MD_NORMAL: tpd_nxt = 1'b0;
      MD_HWRST, MD_SFTPD, MD_SLEEP: begin
        rxd_nxt = '0;
        dv_nxt = 1'b0;
        er_nxt = 1'b0;
        col_nxt = 1'b0;
        crs_nxt = 1'b0;
        if (mode_w == MD_HWRST) begin
          txc_nxt = 1'b1;
          rxc_nxt = 1'b1;
        end else if (mode_w == MD_SLEEP) begin
          txc_nxt = 1'b0;
          rxc_nxt = 1'b0;
        end
      end
      MD_ISO: begin
        oe_nxt = 1'b0;
        opd_nxt = 1'b1;
      end
      MD_HWPD: begin
        oe_nxt = 1'b0;
        tpd_nxt = 1'b0;
      end
      default: begin
        oe_nxt = 1'b0;
        tpd_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rxd_r <= '0;
      dv_r <= 1'b0;
      er_r <= 1'b0;
      col_r <= 1'b0;
      crs_r <= 1'b0;
      txc_r <= 1'b1;
      rxc_r <= 1'b1;
      oe_r <= 1'b1;
      opd_r <= 1'b0;
      tpd_r <= 1'b1;
    end else begin
      rxd_r <= rxd_nxt;
      dv_r <= dv_nxt;
      er_r <= er_nxt;
      col_r <= col_nxt;
      crs_r <= crs_nxt;
      txc_r <= txc_nxt;
      rxc_r <= rxc_nxt;
      oe_r <= oe_nxt;
      opd_r <= opd_nxt;
      tpd_r <= tpd_nxt;
    end
  end

  assign mii_rxd_o = rxd_r;
  assign mii_rx_dv_o = dv_r;
  assign mii_rx_er_o = er_r;
  assign mii_col_o = col_r;
  assign mii_crs_o = crs_r;
  assign mii_tx_clk_o = txc_r;
  assign mii_rx_clk_o = rxc_r;
  assign mii_out_oe_o = oe_r;
  assign mii_out_pd_o = opd_r;
  assign mii_tx_pd_o = tpd_r;

  ppm_link_t lk_r, lk_nxt;
  logic up_r, up_nxt, spd_r, spd_nxt, fdx_r, fdx_nxt, flp_r, flp_nxt;

  // Line resolution: forced by strap, negotiated, or parallel detect
  always_comb begin
    lk_nxt = lk_r;
    up_nxt = up_r;
    spd_nxt = spd_r;
    fdx_nxt = fdx_r;
    flp_nxt = 1'b0;
    case (lk_r)
      LK_IDLE: begin
        up_nxt = 1'b0;
        if (!in_rst && !strap_r[STRAP_AN_BIT]) begin
          lk_nxt = LK_UP;
          up_nxt = 1'b1;
          spd_nxt = strap_r[STRAP_SPD_BIT];
          fdx_nxt = strap_r[STRAP_FDX_BIT];
        end else if (!in_rst) begin
          lk_nxt = LK_NEG;
          flp_nxt = 1'b1;
        end
      end
      LK_NEG: begin
        flp_nxt = 1'b1;
        if (an_complete_i) begin
          lk_nxt = LK_UP;
          up_nxt = 1'b1;
          flp_nxt = 1'b0;
          spd_nxt = an_speed100_i;
          fdx_nxt = an_full_dx_i;
        end else if (!partner_flp_i && (idle_det_i || nlp_det_i)) begin
          lk_nxt = LK_UP;
          up_nxt = 1'b1;
          flp_nxt = 1'b0;
          spd_nxt = idle_det_i;                     // Idles win over pulses
          fdx_nxt = 1'b0;                           // Detect gives half
        end
      end
      LK_UP: begin
        if (link_lost_i) begin
          lk_nxt = LK_IDLE;
          up_nxt = 1'b0;
        end
      end
      default: begin
        lk_nxt = LK_IDLE;
        up_nxt = 1'b0;
      end
    endcase
    if (in_rst) begin
      lk_nxt = LK_IDLE;
      up_nxt = 1'b0;
      flp_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lk_r <= LK_IDLE;
      up_r <= 1'b0;
      spd_r <= 1'b0;
      fdx_r <= 1'b0;
      flp_r <= 1'b0;
    end else begin
      lk_r <= lk_nxt;
      up_r <= up_nxt;
      spd_r <= spd_nxt;
      fdx_r <= fdx_nxt;
      flp_r <= flp_nxt;
    end
  end

  assign link_up_o = up_r;
  assign speed100_o = spd_r;
  assign full_dx_o = fdx_r;
  assign flp_tx_en_o = flp_r;

  logic [LED_NUM-1:0] led_r, led_nxt, led_oe_r, led_oe_nxt;

  // LEDs: released during reset to read straps, floated in power-down
  always_comb begin
    for (int i = 0; i < LED_NUM; i++) begin
      led_nxt[i] = led_pick(led_sel_i[i*LED_SEL_W +: LED_SEL_W],
                            up_r, spd_r, fdx_r, activity_i);
    end
    led_oe_nxt = (mode_w == MD_HWRST || mode_w == MD_HWPD) ?
                 '0 : '1;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      led_r <= '0;
      led_oe_r <= '0;
    end else begin
      led_r <= led_nxt;
      led_oe_r <= led_oe_nxt;
    end
  end

  assign led_pin_o = led_r;
  assign led_pin_oe_o = led_oe_r;

  logic tck_d_r, tck_d_nxt, tap_r, tap_nxt, tdo_r, tdo_nxt;
  logic tck_rise, tck_fall;

  // Test port edges seen on the sampled test clock; a one-bit bypass
  assign tck_rise = tck_i && !tck_d_r;
  assign tck_fall = !tck_i && tck_d_r;
  always_comb begin
    tck_d_nxt = tck_i;
    tap_nxt = tck_rise ? tdi_i : tap_r;
    tdo_nxt = tck_fall ? tap_r : tdo_r;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tck_d_r <= 1'b0;
      tap_r <= 1'b0;
      tdo_r <= 1'b0;
    end else begin
      tck_d_r <= tck_d_nxt;
      tap_r <= tap_nxt;
      tdo_r <= tdo_nxt;
    end
  end

  assign tdo_o = tdo_r;

  // Checks on the pin modes, stretch, straps, resolution and test port
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_low_data;
    mii_out_oe_o && mii_rxd_o == '0 && !mii_rx_dv_o && !mii_rx_er_o
      && !mii_col_o && !mii_crs_o && mii_tx_pd_o;
  endsequence
  sequence s_float_pd;
    !mii_out_oe_o && mii_out_pd_o && mii_tx_pd_o;
  endsequence

  rst_pins_a: assert property (mode_w == MD_HWRST |=>
    s_low_data ##0 (mii_tx_clk_o && mii_rx_clk_o))
    else $error("reset pin state wrong");
  sleep_pins_a: assert property (mode_w == MD_SLEEP |=>
    s_low_data ##0 (!mii_tx_clk_o && !mii_rx_clk_o))
    else $error("sleep pin state wrong");
  sftpd_clk_a: assert property (mode_w == MD_SFTPD |=>
    s_low_data ##0 (mii_tx_clk_o == $past(core_tx_clk_i)))
    else $error("soft power-down clock not running");
  iso_float_a: assert property (mode_w == MD_ISO |=> s_float_pd)
    else $error("isolate pins not floated with pulls");
  hwpd_float_a: assert property (
    hardware_power_down_mode_i |=> !mii_out_oe_o && !mii_out_pd_o
      && !mii_tx_pd_o && led_pin_oe_o == '0)
    else $error("power-down pins not fully floated");
  // Judged on the pins, so a broken priority chain shows up here
  hwpd_wins_a: assert property (
    hardware_power_down_mode_i && (isolate_i || in_rst || sleep_i
      || soft_power_down_mode_i) |=> !mii_out_oe_o && !mii_out_pd_o
      && !mii_tx_pd_o && led_pin_oe_o == '0)
    else $error("power-down lost priority");
  rst_load_a: assert property (
    soft_reset_i |=> in_rst && rst_cnt_r == RST_CNT_W'(RST_CYC))
    else $error("reset stretch not restarted");
  strap_cap_a: assert property (
    rst_cnt_r == RST_CNT_LAST && !soft_reset_i |=> !in_rst
      && strap_r == $past(led_pin_i) && led_pin_oe_o == '0)
    else $error("straps not captured at reset end");
  forced_a: assert property (
    lk_r == LK_IDLE && !in_rst && !strap_r[STRAP_AN_BIT] |=> link_up_o
      && speed100_o == $past(strap_r[STRAP_SPD_BIT]) && !flp_tx_en_o)
    else $error("forced strap not applied");
  par_det_a: assert property (
    lk_r == LK_NEG && !in_rst && !an_complete_i && !partner_flp_i
      && idle_det_i |=> link_up_o && speed100_o && !full_dx_o)
    else $error("idle detect did not pick 100");
  tdi_rise_a: assert property (
    tck_i && !tck_d_r |=> tap_r == $past(tdi_i))
    else $error("test input not taken on rise");
  tdo_fall_a: assert property (
    tdo_o != $past(tdo_o) |-> $past(tck_d_r) && !$past(tck_i))
    else $error("test output moved off a fall");

endmodule : ppm_pin_mode_ctrl

// ===== ppm_mac_model.sv
// MAC side of the MII: works out the level each receive wire carries.
// Assumes pin values, output enable and pull flag come from the device.
`timescale 1ns/10ps
module ppm_mac_model
  import ppm_pkg::*;
(
  input wire logic clk_sys_i,    // System clock
  input wire logic resetn_i,     // Async reset, low
  input wire logic [9:0] pin_i,  // Values the device drives
  input wire logic oe_i,         // Device drives the wires
  input wire logic pd_i,         // Weak pull-down present
  output logic [9:0] wire_o      // Levels the MAC receives
);
  logic [9:0] last_r;
  logic [9:0] last_nxt;

  // A floating wire shows a pattern that changes every cycle, so a
  // stale level can never pass for a driven one
  always_comb begin
    if (oe_i) begin
      wire_o = pin_i;
    end else if (pd_i) begin
      wire_o = 10'h000;
    end else begin
      wire_o = ~last_r;
    end
    last_nxt = wire_o;
  end

  // Last level seen on each wire
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_r <= 10'h155;
    end else begin
      last_r <= last_nxt;
    end
  end
endmodule : ppm_mac_model

// ===== ppm_pin_mode_ctrl_test.sv
// Testbench for the pin mode controller: straps, line resolution, LEDs,
// pin modes, soft reset and test port edges.
// Assumes a short reset stretch; inputs change on the falling edge.
`timescale 1ns/10ps
module ppm_pin_mode_ctrl_test;
  import ppm_pkg::*;
  localparam int RST_SIM = 8;
  logic clk_sys_i, resetn_i, soft_reset_i;
  logic hardware_power_down_mode_i, soft_power_down_mode_i;
  logic isolate_i, sleep_i;
  logic [3:0] core_rxd_i, mii_rxd_o;
  logic core_rx_dv_i, core_rx_er_i, core_col_i, core_crs_i;
  logic core_tx_clk_i, core_rx_clk_i;
  logic mii_rx_dv_o, mii_rx_er_o, mii_col_o, mii_crs_o;
  logic mii_tx_clk_o, mii_rx_clk_o;
  logic mii_out_oe_o, mii_out_pd_o, mii_tx_pd_o;
  logic [2:0] led_pin_i, led_pin_o, led_pin_oe_o, strap;
  logic [5:0] led_sel_i, fl;
  logic activity_i, partner_flp_i, an_complete_i, an_speed100_i;
  logic an_full_dx_i, nlp_det_i, idle_det_i, link_lost_i;
  logic tck_i, tdi_i, tdo_o;
  logic flp_tx_en_o, link_up_o, speed100_o, full_dx_o, an_enable_o;
  logic [9:0] core_v, mw;
  logic [4:0] ls;
  int n_fail = 0;
  int check_count = 0;

  // Core values, shared LED wire, and status bundles
  assign {core_rxd_i, core_rx_dv_i, core_rx_er_i, core_col_i, core_crs_i,
          core_tx_clk_i, core_rx_clk_i} = core_v;
  assign led_pin_i = (led_pin_o & led_pin_oe_o) | (strap & ~led_pin_oe_o);
  assign ls = {link_up_o, speed100_o, full_dx_o, flp_tx_en_o, an_enable_o};
  assign fl = {mii_out_oe_o, mii_out_pd_o, mii_tx_pd_o, led_pin_oe_o};

  ppm_pin_mode_ctrl #(.RST_CYC(RST_SIM)) dut (
    .clk_sys_i, .resetn_i, .soft_reset_i, .hardware_power_down_mode_i,
    .soft_power_down_mode_i, .isolate_i, .sleep_i, .core_rxd_i,
    .core_rx_dv_i, .core_rx_er_i, .core_col_i, .core_crs_i,
    .core_tx_clk_i, .core_rx_clk_i, .mii_rxd_o, .mii_rx_dv_o,
    .mii_rx_er_o, .mii_col_o, .mii_crs_o, .mii_tx_clk_o, .mii_rx_clk_o,
    .mii_out_oe_o, .mii_out_pd_o, .mii_tx_pd_o, .led_pin_i, .led_pin_o,
    .led_pin_oe_o, .led_sel_i, .activity_i, .partner_flp_i,
    .an_complete_i, .an_speed100_i, .an_full_dx_i, .nlp_det_i,
    .idle_det_i, .link_lost_i, .flp_tx_en_o, .link_up_o, .speed100_o,
    .full_dx_o, .an_enable_o, .tck_i, .tdi_i, .tdo_o);

  ppm_mac_model mac (
    .clk_sys_i, .resetn_i,
    .pin_i({mii_rxd_o, mii_rx_dv_o, mii_rx_er_o, mii_col_o, mii_crs_o,
            mii_tx_clk_o, mii_rx_clk_o}),
    .oe_i(mii_out_oe_o), .pd_i(mii_out_pd_o), .wire_o(mw));

  // 250 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic nc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : nc

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // Reset with a strap pattern, then wait out the stretch
  task automatic do_reset(input logic [2:0] s);
    strap = s;
    resetn_i = 1'b0;
    nc(6);
    chk({mw, fl}, {10'h003, 6'h28});
    resetn_i = 1'b1;
    nc(RST_SIM - 2);
    chk(16'(fl), 16'h28);
    nc(5);
    chk(16'(led_pin_oe_o), 16'h7);
  endtask : do_reset

  // Forced 10 full duplex straps, then every LED selection
  task automatic t_forced;
    do_reset(3'h4);
    nc(3);
    chk(16'(ls), 16'h14);
    for (int k = 0; k < 4; k++) begin
      led_sel_i = {3{k[1:0]}};
      nc(2);
      chk(16'(led_pin_o), k[0] ? 16'h0 : 16'h7);
    end
    activity_i = 1'b1;
    led_sel_i = {2'h3, 2'h2, 2'h1};
    nc(2);
    chk(16'(led_pin_o), 16'h6);
    $display("test forced done");
  endtask : t_forced

  // Negotiation, then parallel detection of both speeds
  task automatic t_neg;
    do_reset(3'h1);
    nc(3);
    chk(16'(ls), 16'h03);
    {an_complete_i, an_speed100_i, an_full_dx_i} = 3'h7;
    nc(3);
    chk(16'(ls), 16'h1D);
    {an_complete_i, link_lost_i, partner_flp_i, idle_det_i} = 4'h7;
    nc(3);
    chk(16'(link_up_o), 16'h0);
    link_lost_i = 1'b0;
    nc(4);
    chk(16'(link_up_o), 16'h0);
    partner_flp_i = 1'b0;
    nc(3);
    chk(16'(ls), 16'h19);
    {link_lost_i, idle_det_i, nlp_det_i} = 3'h5;
    nc(2);
    link_lost_i = 1'b0;
    nc(4);
    chk(16'(ls), 16'h11);
    $display("test negotiate done");
  endtask : t_neg

  // One mode request; power-down wires must keep changing
  task automatic mode_case(input logic [3:0] m, input logic [9:0] ew,
                           input logic [5:0] ef);
    logic [9:0] w;
    {hardware_power_down_mode_i, soft_power_down_mode_i,
     isolate_i, sleep_i} = m;
    nc(3);
    if (m[3]) begin
      w = mw;
      nc(1);
      ew = ~w;
    end
    chk({mw, fl}, {ew, ef});
  endtask : mode_case

  task automatic t_modes;
    core_v = 10'h155;
    mode_case(4'h0, 10'h155, 6'h27);
    core_v = 10'h3FE;
    mode_case(4'h0, 10'h3FE, 6'h27);
    mode_case(4'h4, 10'h002, 6'h2F);
    mode_case(4'h1, 10'h000, 6'h2F);
    mode_case(4'h2, 10'h000, 6'h1F);
    mode_case(4'h8, 10'h000, 6'h00);
    mode_case(4'hF, 10'h000, 6'h00);
    mode_case(4'h0, 10'h3FE, 6'h27);
    $display("test modes done");
  endtask : t_modes

  // Control reset bit restarts the stretch
  task automatic t_soft;
    soft_reset_i = 1'b1;
    nc(1);
    soft_reset_i = 1'b0;
    nc(RST_SIM - 3);
    chk({mw, fl}, {10'h003, 6'h28});
    nc(6);
    chk(16'(led_pin_oe_o), 16'h7);
    $display("test soft reset done");
  endtask : t_soft

  // Data in taken at the rise only, data out moves at the fall only
  task automatic t_tap;
    {tck_i, tdi_i} = 2'h1;
    nc(2);
    tck_i = 1'b1;
    nc(2);
    {tck_i, tdi_i} = 2'h0;
    nc(3);
    chk(16'(tdo_o), 16'h1);
    tck_i = 1'b1;
    nc(3);
    chk(16'(tdo_o), 16'h1);
    tck_i = 1'b0;
    nc(3);
    chk(16'(tdo_o), 16'h0);
    $display("test test port done");
  endtask : t_tap

  // Main sequence
  initial begin
    {soft_reset_i, hardware_power_down_mode_i, soft_power_down_mode_i,
     isolate_i, sleep_i, activity_i, partner_flp_i, an_complete_i,
     an_speed100_i, an_full_dx_i, nlp_det_i, idle_det_i, link_lost_i,
     tck_i, tdi_i, led_sel_i, strap} = '0;
    resetn_i = 1'b0;
    core_v = 10'h3FE;
    t_forced;
    t_neg;
    t_modes;
    t_soft;
    t_tap;
    summarize;
  end

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    n_fail++;
    summarize;
  end
endmodule : ppm_pin_mode_ctrl_test
